// >>> dpai_defines.svh
`ifndef DPAI_DEFINES_SVH
`define DPAI_DEFINES_SVH
// =====================================================
// block dimensions
`define DPAI_NUM_CH 4
`define DPAI_CH_IDX_W 2
`define DPAI_LVL_W 3
`define DPAI_CNT_W 16
`define DPAI_STATE_W 5
// =====================================================
// priority values
// level the cpu takes while its priority control is off
`define DPAI_LVL_LOWEST 3'h0
// =====================================================
// reset values
`define DPAI_FLAG_RST 1'h0
`define DPAI_CH_RST 2'h0
`endif

// >>> dpai_pkg.sv
// =====================================================
// shared types
package dpai_pkg;
`include "dpai_defines.svh"
  // bus sequencer states, one-hot
  typedef enum logic [`DPAI_STATE_W-1:0] {
    st_idle = 5'h01,
    st_read = 5'h02,
    st_write = 5'h04,
    st_yield = 5'h08,
    st_release = 5'h10
  } dpai_state_t;
endpackage

// >>> dpai_chan_gate.sv
`timescale 1ns/1ps
`include "dpai_defines.svh"
// =====================================================
// per-channel enable, pending request and cpu priority mask
module dpai_chan_gate (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`DPAI_LVL_W-1:0] channel_priority_level_in,
  input wire logic [`DPAI_LVL_W-1:0] cpu_priority_level_in,
  input wire logic cpu_priority_ctrl_enable_in,
  input wire logic req_in,
  input wire logic enable_set_in,
  input wire logic enable_clr_in,
  input wire logic terminate_in,
  input wire logic grant_in,
  output logic eligible_out,
  output logic pending_out,
  output logic enable_out
);
  logic [`DPAI_LVL_W-1:0] eff_cpu_level; // cpu level as seen by the mask
  logic masked; // cpu currently outranks this channel
  logic pending_reg;
  logic enable_reg;

  assign eff_cpu_level = cpu_priority_ctrl_enable_in ? cpu_priority_level_in : `DPAI_LVL_LOWEST;
  assign masked = eff_cpu_level > channel_priority_level_in;
  assign eligible_out = pending_reg & enable_reg & ~masked;
  assign pending_out = pending_reg;
  assign enable_out = enable_reg;

  // transfer enable: software restart wins over a same-cycle end
  // counter end clears
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      enable_reg <= `DPAI_FLAG_RST;
    end else if (enable_set_in) begin
      enable_reg <= 1'h1;
    end else if (enable_clr_in || terminate_in) begin
      enable_reg <= 1'h0;
    end
  end

  // pending request; a masked one simply waits here
  // masked request held
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pending_reg <= `DPAI_FLAG_RST;
    end else if (enable_clr_in) begin
      pending_reg <= 1'h0;
    end else if (grant_in) begin
      pending_reg <= req_in;
    end else if (req_in && enable_reg) begin
      pending_reg <= 1'h1;
    end
  end

  mask_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pending_reg && masked && !enable_clr_in |=> pending_reg)
    else $error("masked request was lost");
  clr_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    enable_clr_in |=> !pending_reg)
    else $error("pending request survived disable");
  ctrl_off_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cpu_priority_ctrl_enable_in && pending_reg && enable_reg |-> eligible_out)
    else $error("request masked with cpu control off");
  end_clear_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    terminate_in && !enable_set_in |=> !enable_reg)
    else $error("enable kept after transfer end");
endmodule

// >>> dpai_irq_chan.sv
`timescale 1ns/1ps
`include "dpai_defines.svh"
// =====================================================
// per-channel end flags and interrupt request levels
module dpai_irq_chan (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic counter_zero_in,
  input wire logic size_error_in,
  input wire logic repeat_end_in,
  input wire logic src_overflow_in,
  input wire logic dst_overflow_in,
  input wire logic counter_end_irq_enable_in,
  input wire logic escape_irq_enable_in,
  input wire logic size_error_enable_in,
  input wire logic repeat_end_enable_in,
  input wire logic source_area_overflow_enable_in,
  input wire logic dest_area_overflow_enable_in,
  input wire logic counter_end_flag_clr_in,
  input wire logic escape_flag_clr_in,
  output logic terminate_out,
  output logic counter_end_flag_out,
  output logic escape_flag_out,
  output logic counter_end_irq_out,
  output logic escape_end_irq_out
);
  logic escape_hit; // any enabled escape cause this cycle
  logic cnt_flag_next;
  logic esc_flag_next;

  assign escape_hit = (size_error_in & size_error_enable_in) | (repeat_end_in & repeat_end_enable_in) |
                      (src_overflow_in & source_area_overflow_enable_in) |
                      (dst_overflow_in & dest_area_overflow_enable_in);
  assign terminate_out = counter_zero_in | escape_hit;
  // set on zero count while the end request is enabled; set beats clear
  assign cnt_flag_next = (counter_zero_in & counter_end_irq_enable_in) |
                         (counter_end_flag_out & ~counter_end_flag_clr_in);
  assign esc_flag_next = escape_hit | (escape_flag_out & ~escape_flag_clr_in);

  // flags and request levels; request tracks flag and enable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      counter_end_flag_out <= `DPAI_FLAG_RST;
      escape_flag_out <= `DPAI_FLAG_RST;
      counter_end_irq_out <= `DPAI_FLAG_RST;
      escape_end_irq_out <= `DPAI_FLAG_RST;
    end else begin
      counter_end_flag_out <= cnt_flag_next;
      escape_flag_out <= esc_flag_next;
      counter_end_irq_out <= cnt_flag_next & counter_end_irq_enable_in;
      escape_end_irq_out <= esc_flag_next & escape_irq_enable_in;
    end
  end

  cnt_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    counter_zero_in && counter_end_irq_enable_in |=> counter_end_flag_out)
    else $error("counter end flag not set");
  esc_set_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    escape_hit |=> escape_flag_out)
    else $error("escape flag not set");
  irq_level_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    escape_end_irq_out == (escape_flag_out && $past(escape_irq_enable_in)))
    else $error("escape request does not follow flag");
endmodule

// >>> dpai_top.sv
`timescale 1ns/1ps
`include "dpai_defines.svh"
// How it works
// - each channel and cpu hold levels
// - cpu above channel masks its request
// - equal or higher channel starts regardless
// - masked request waits, resumes on change
// - disabling a channel drops pending request
// - control off makes cpu lowest priority
// - read and write never split apart
// - block or burst runs back to back
// - channel change or steal alternates masters
// - arbitration enable alternates except pairs
// - external release pauses burst, then resumes
// - external access: bus released only after write cycle
// - internal access overlaps external release
// - two requests per channel, fixed order
// - end request from flag and enable
// - escape request shared by all causes
// - every cause has its own enable
// - zero count sets end flag when its end request is enabled
// - enabled cause sets escape flag
// - short count raises size error
// - finished repeat size raises repeat end
// - address beyond area raises overflow
// - zero count clears transfer enable
// - escape ends transfer and sets flag
module dpai_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [`DPAI_LVL_W-1:0] cpu_priority_level_in,
  input wire logic cpu_priority_ctrl_enable_in,
  input wire logic [`DPAI_NUM_CH*`DPAI_LVL_W-1:0] channel_priority_level_in,
  input wire logic [`DPAI_NUM_CH-1:0] chan_req_in,
  input wire logic [`DPAI_NUM_CH-1:0] transfer_enable_set_in,
  input wire logic [`DPAI_NUM_CH-1:0] transfer_enable_clr_in,
  input wire logic [`DPAI_NUM_CH-1:0] block_mode_in,
  input wire logic [`DPAI_NUM_CH-1:0] burst_auto_in,
  input wire logic [`DPAI_NUM_CH-1:0] repeat_mode_in,
  input wire logic onchip_master_req_in,
  input wire logic onchip_master_arbitration_enable_in,
  input wire logic ext_release_req_in,
  input wire logic dma_external_in,
  input wire logic bus_cycle_done_in,
  input wire logic [`DPAI_CNT_W-1:0] remaining_count_in,
  input wire logic [`DPAI_CNT_W-1:0] access_size_in,
  input wire logic [`DPAI_CNT_W-1:0] block_size_in,
  input wire logic repeat_size_done_in,
  input wire logic [`DPAI_NUM_CH-1:0] counter_zero_in,
  input wire logic [`DPAI_NUM_CH-1:0] src_overflow_in,
  input wire logic [`DPAI_NUM_CH-1:0] dst_overflow_in,
  input wire logic [`DPAI_NUM_CH-1:0] counter_end_irq_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] escape_irq_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] size_error_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] repeat_end_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] source_area_overflow_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] dest_area_overflow_enable_in,
  input wire logic [`DPAI_NUM_CH-1:0] counter_end_flag_clr_in,
  input wire logic [`DPAI_NUM_CH-1:0] escape_flag_clr_in,
  output logic [`DPAI_NUM_CH-1:0] transfer_enable_out,
  output logic [`DPAI_NUM_CH-1:0] pending_out,
  output logic [`DPAI_NUM_CH-1:0] counter_end_flag_out,
  output logic [`DPAI_NUM_CH-1:0] escape_flag_out,
  output logic [`DPAI_NUM_CH-1:0] counter_end_irq_out,
  output logic [`DPAI_NUM_CH-1:0] escape_end_irq_out,
  output logic dma_read_out,
  output logic dma_write_out,
  output logic [`DPAI_CH_IDX_W-1:0] active_chan_out,
  output logic onchip_grant_out,
  output logic ext_release_grant_out
);
  // =====================================================
  // declarations
  dpai_pkg::dpai_state_t state_reg; // bus sequencer state
  dpai_pkg::dpai_state_t state_next;
  logic [`DPAI_CH_IDX_W-1:0] chan_reg; // channel owning the current transfer
  logic [`DPAI_CH_IDX_W-1:0] chan_next;
  logic [`DPAI_NUM_CH-1:0] eligible; // pending, enabled and not masked
  logic [`DPAI_NUM_CH-1:0] grant_vec; // one-cycle take of a pending request
  logic [`DPAI_NUM_CH-1:0] terminate; // transfer end per channel
  logic [`DPAI_NUM_CH-1:0] size_error; // size error per channel
  logic [`DPAI_NUM_CH-1:0] repeat_end; // repeat end per channel
  logic [`DPAI_CH_IDX_W-1:0] first_ch; // lowest eligible channel
  logic any_elig; // some channel may start
  logic cont_mode; // current channel runs block or burst
  logic ext_pause; // release request meets an external dma access
  logic must_alternate; // next slot belongs to an on-chip master
  logic short_count; // remaining count below the next unit
  logic dma_read_reg;
  logic dma_write_reg;
  logic onchip_grant_reg;
  logic ext_release_grant_reg;
  logic [`DPAI_CH_IDX_W-1:0] active_chan_reg;

  // =====================================================
  // channel selection
  // lowest index wins among eligible; channels at or above the cpu
  // are not ranked against each other, so a fixed scan is enough
  always_comb begin
    any_elig = |eligible;
    first_ch = `DPAI_CH_RST;
    for (int i = `DPAI_NUM_CH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        first_ch = i[`DPAI_CH_IDX_W-1:0];
      end
    end
  end

  assign cont_mode = block_mode_in[chan_reg] | burst_auto_in[chan_reg];
  // only an external dma access conflicts with a bus release
  assign ext_pause = ext_release_req_in & dma_external_in;
  assign must_alternate = onchip_master_req_in & (~cont_mode | onchip_master_arbitration_enable_in |
                          ~eligible[chan_reg] | (first_ch != chan_reg));

  // =====================================================
  // escape causes computed here for the owning channel
  // count below unit size
  assign short_count = block_mode_in[chan_reg] ? (remaining_count_in < block_size_in)
                                               : (remaining_count_in < access_size_in);

  // causes only fire when the owner asks for its next transfer
  always_comb begin
    size_error = '0;
    repeat_end = '0;
    if (chan_req_in[chan_reg] && transfer_enable_out[chan_reg]) begin
      size_error[chan_reg] = short_count;
      repeat_end[chan_reg] = repeat_mode_in[chan_reg] & repeat_size_done_in;
    end
  end

  // =====================================================
  // per-channel gate and interrupt logic
  generate
    for (genvar g = 0; g < `DPAI_NUM_CH; g++) begin : g_chan
      dpai_chan_gate u_gate (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .channel_priority_level_in(channel_priority_level_in[g*`DPAI_LVL_W +: `DPAI_LVL_W]),
        .cpu_priority_level_in(cpu_priority_level_in),
        .cpu_priority_ctrl_enable_in(cpu_priority_ctrl_enable_in),
        .req_in(chan_req_in[g]),
        .enable_set_in(transfer_enable_set_in[g]),
        .enable_clr_in(transfer_enable_clr_in[g]),
        .terminate_in(terminate[g]),
        .grant_in(grant_vec[g]),
        .eligible_out(eligible[g]),
        .pending_out(pending_out[g]),
        .enable_out(transfer_enable_out[g])
      );
      dpai_irq_chan u_irq (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .counter_zero_in(counter_zero_in[g]),
        .size_error_in(size_error[g]),
        .repeat_end_in(repeat_end[g]),
        .src_overflow_in(src_overflow_in[g]),
        .dst_overflow_in(dst_overflow_in[g]),
        .counter_end_irq_enable_in(counter_end_irq_enable_in[g]),
        .escape_irq_enable_in(escape_irq_enable_in[g]),
        .size_error_enable_in(size_error_enable_in[g]),
        .repeat_end_enable_in(repeat_end_enable_in[g]),
        .source_area_overflow_enable_in(source_area_overflow_enable_in[g]),
        .dest_area_overflow_enable_in(dest_area_overflow_enable_in[g]),
        .counter_end_flag_clr_in(counter_end_flag_clr_in[g]),
        .escape_flag_clr_in(escape_flag_clr_in[g]),
        .terminate_out(terminate[g]),
        .counter_end_flag_out(counter_end_flag_out[g]),
        .escape_flag_out(escape_flag_out[g]),
        .counter_end_irq_out(counter_end_irq_out[g]),
        .escape_end_irq_out(escape_end_irq_out[g])
      );
    end
  endgenerate

  // =====================================================
  // bus sequencer next state
  always_comb begin
    state_next = state_reg;
    chan_next = chan_reg;
    case (state_reg)
      dpai_pkg::st_idle: begin
        // a paused burst owner gets first claim on the bus again
        if (cont_mode && eligible[chan_reg]) begin
          state_next = dpai_pkg::st_read;
        end else if (any_elig) begin
          state_next = dpai_pkg::st_read;
          chan_next = first_ch;
        end
      end
      dpai_pkg::st_read: begin
        if (bus_cycle_done_in) begin
          state_next = dpai_pkg::st_write;
        end
      end
      dpai_pkg::st_write: begin
        if (bus_cycle_done_in) begin
          if (ext_pause) begin
            state_next = dpai_pkg::st_release;
          end else if (must_alternate) begin
            state_next = dpai_pkg::st_yield;
          end else if (cont_mode && eligible[chan_reg]) begin
            state_next = dpai_pkg::st_read;
          end else if (any_elig) begin
            state_next = dpai_pkg::st_read;
            chan_next = first_ch;
          end else begin
            state_next = dpai_pkg::st_idle;
          end
        end
      end
      dpai_pkg::st_yield: begin
        // on-chip master holds the bus for one bus cycle
        if (bus_cycle_done_in) begin
          state_next = dpai_pkg::st_idle;
        end
      end
      dpai_pkg::st_release: begin
        if (!ext_release_req_in) begin
          state_next = dpai_pkg::st_idle;
        end
      end
      default: begin
        // illegal code recovers to idle
        state_next = dpai_pkg::st_idle;
      end
    endcase
  end

  // take the pending request as the read cycle starts
  always_comb begin
    grant_vec = '0;
    if (state_next == dpai_pkg::st_read && state_reg != dpai_pkg::st_read) begin
      grant_vec[chan_next] = 1'h1;
    end
  end

  // =====================================================
  // sequencer state registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= dpai_pkg::st_idle;
      chan_reg <= `DPAI_CH_RST;
    end else begin
      state_reg <= state_next;
      chan_reg <= chan_next;
    end
  end

  // =====================================================
  // registered bus outputs, decoded from the next state
  // so they line up with the state register
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dma_read_reg <= 1'h0;
      dma_write_reg <= 1'h0;
      active_chan_reg <= `DPAI_CH_RST;
      onchip_grant_reg <= 1'h0;
      ext_release_grant_reg <= 1'h0;
    end else begin
      dma_read_reg <= state_next == dpai_pkg::st_read;
      dma_write_reg <= state_next == dpai_pkg::st_write;
      active_chan_reg <= chan_next;
      onchip_grant_reg <= (state_next == dpai_pkg::st_yield) |
                          ((state_next == dpai_pkg::st_idle) & onchip_master_req_in);
      ext_release_grant_reg <= ext_release_req_in & (~dma_external_in |
                               ((state_next != dpai_pkg::st_read) & (state_next != dpai_pkg::st_write)));
    end
  end

  assign dma_read_out = dma_read_reg;
  assign dma_write_out = dma_write_reg;
  assign active_chan_out = active_chan_reg;
  assign onchip_grant_out = onchip_grant_reg;
  assign ext_release_grant_out = ext_release_grant_reg;

  // =====================================================
  // checks on the sequencer
  // read then write
  rw_pair_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dma_read_out && bus_cycle_done_in |=> dma_write_out && !onchip_grant_out)
    else $error("read not followed by its write");
  rel_after_wr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_release_grant_out && dma_external_in |-> !dma_read_out && !dma_write_out)
    else $error("external bus released inside a transfer");
  burst_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dma_write_out && bus_cycle_done_in && cont_mode && eligible[chan_reg] && !ext_pause && !must_alternate
    |=> dma_read_out && !onchip_grant_out)
    else $error("burst transfer was broken up");
  steal_alt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dma_write_out && bus_cycle_done_in && !cont_mode && onchip_master_req_in && !ext_pause
    |=> onchip_grant_out ##1 !dma_read_out)
    else $error("cycle steal did not yield the bus");
  arb_alt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dma_write_out && bus_cycle_done_in && onchip_master_arbitration_enable_in && onchip_master_req_in
    && !ext_pause |=> onchip_grant_out)
    else $error("arbitration enable did not alternate");
  rel_pause_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    dma_write_out && bus_cycle_done_in && ext_pause |=> ext_release_grant_out && !dma_read_out)
    else $error("release not inserted after write");
  int_overlap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ext_release_req_in && !dma_external_in |=> ext_release_grant_out)
    else $error("release withheld during internal access");
  mask_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    grant_vec != '0 |-> (grant_vec & ~eligible) == '0)
    else $error("masked channel was started");
  size_err_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    chan_req_in[chan_reg] && transfer_enable_out[chan_reg] && short_count && size_error_enable_in[chan_reg]
    |=> escape_flag_out[$past(chan_reg)])
    else $error("size error did not raise the escape flag");
endmodule

// >>> dpai_bus_partner.sv
`timescale 1ns/1ps
// =====================================================
// far side: ends each granted bus cycle after a set wait
module dpai_bus_partner (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic busy_in,
  input wire logic [3:0] wait_in,
  output logic done_out
);
  logic [3:0] wait_reg; // cycles spent in the current bus cycle
  // one-cycle done pulse; the count restarts so back-to-back cycles each wait
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || done_out || !busy_in) begin
      wait_reg <= 4'h0;
      done_out <= 1'b0;
    end else if (wait_reg >= wait_in) begin
      done_out <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// >>> dpai_top_tb_top.sv
`timescale 1ns/1ps
module dpai_top_tb_top;
  // =====================================================
  // stimulus, named as the ports so the instance connects by name
  logic clk_in = 1'b0, rst_n_in = 1'b0, cpu_priority_ctrl_enable_in = 1'b0, onchip_master_req_in = 1'b0;
  logic onchip_master_arbitration_enable_in = 1'b0, ext_release_req_in = 1'b0, dma_external_in = 1'b0;
  logic repeat_size_done_in = 1'b0, bus_cycle_done_in;
  logic [2:0] cpu_priority_level_in = 3'h0;
  logic [11:0] channel_priority_level_in = 12'h003;
  logic [3:0] chan_req_in = 4'h0, transfer_enable_set_in = 4'h0, transfer_enable_clr_in = 4'h0, wait_cycles = 4'h0;
  logic [3:0] block_mode_in = 4'h0, burst_auto_in = 4'h0, repeat_mode_in = 4'h0, counter_zero_in = 4'h0;
  logic [3:0] src_overflow_in = 4'h0, dst_overflow_in = 4'h0, counter_end_irq_enable_in = 4'h0;
  logic [3:0] escape_irq_enable_in = 4'h8, size_error_enable_in = 4'h0, repeat_end_enable_in = 4'h0;
  logic [3:0] source_area_overflow_enable_in = 4'h0, dest_area_overflow_enable_in = 4'h0;
  logic [3:0] counter_end_flag_clr_in = 4'h0, escape_flag_clr_in = 4'h0;
  logic [15:0] remaining_count_in = 16'h0010, access_size_in = 16'h0001, block_size_in = 16'h0004;
  logic [3:0] transfer_enable_out, pending_out, counter_end_flag_out, escape_flag_out;
  logic [3:0] counter_end_irq_out, escape_end_irq_out;
  logic dma_read_out, dma_write_out, onchip_grant_out, ext_release_grant_out;
  logic [1:0] active_chan_out;
  int n_fail = 0;
  int compares = 0;
  dpai_top DUT (.*);
  dpai_bus_partner PARTNER (.clk_in(clk_in), .rst_n_in(rst_n_in), .wait_in(wait_cycles),
    .busy_in(dma_read_out | dma_write_out | onchip_grant_out), .done_out(bus_cycle_done_in));
  // =====================================================
  // clock and shared tasks
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // inputs always move 1 ns after the rising edge
  task automatic cy(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string s, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic until_rd;
    for (int k = 0; k < 20 && dma_read_out !== 1'b1; k++) cy(1);
    chk("read start", 4'h1, {3'h0, dma_read_out});
  endtask
  task automatic conclude;
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // =====================================================
  // scenarios
  task automatic t_mask;
    cpu_priority_ctrl_enable_in = 1'b1;
    cpu_priority_level_in = 3'h5;
    transfer_enable_set_in = 4'h1;
    cy(1);
    transfer_enable_set_in = 4'h0;
    chan_req_in = 4'h1;
    cy(1);
    chan_req_in = 4'h0;
    cy(5);
    chk("masked read", 4'h0, {3'h0, dma_read_out});
    chk("held pending", 4'h1, pending_out);
    cpu_priority_level_in = 3'h3;
    until_rd;
    cy(8);
    cpu_priority_level_in = 3'h5;
    chan_req_in = 4'h1;
    cy(1);
    chan_req_in = 4'h0;
    transfer_enable_clr_in = 4'h1;
    cy(1);
    transfer_enable_clr_in = 4'h0;
    cpu_priority_level_in = 3'h0;
    cy(4);
    chk("dropped", 4'h0, {pending_out[0], 2'h0, dma_read_out});
  endtask
  task automatic t_off;
    cpu_priority_ctrl_enable_in = 1'b0;
    cpu_priority_level_in = 3'h7;
    transfer_enable_set_in = 4'h2;
    cy(1);
    transfer_enable_set_in = 4'h0;
    chan_req_in = 4'h2;
    cy(1);
    chan_req_in = 4'h0;
    until_rd;
    chk("owner", 4'h1, {2'h0, active_chan_out});
    cy(8);
  endtask
  // a bus release, and in the internal run a master, ask in mid-transfer; only an internal access lets the release in early
  task automatic t_pair(input logic ext);
    wait_cycles = 4'h3;
    chan_req_in = 4'h2;
    cy(1);
    chan_req_in = 4'h0;
    until_rd;
    onchip_master_req_in = !ext;
    ext_release_req_in = 1'b1;
    cy(1);
    while (dma_read_out | dma_write_out) begin
      chk("no insert", {2'h0, !ext, 1'b0}, {2'h0, ext_release_grant_out, onchip_grant_out});
      cy(1);
    end
    chk("handover", ext ? 4'h2 : 4'h3, {2'h0, ext_release_grant_out, onchip_grant_out});
    onchip_master_req_in = 1'b0;
    ext_release_req_in = 1'b0;
    wait_cycles = 4'h0;
    cy(10);
  endtask
  // a burst owner keeps the bus from a waiting master until arbitration is enabled
  task automatic t_burst;
    burst_auto_in = 4'h2;
    onchip_master_req_in = 1'b1;
    chan_req_in = 4'h2;
    until_rd;
    for (int a = 0; a < 2; a++) begin
      onchip_master_arbitration_enable_in = a[0];
      while (dma_read_out) cy(1);
      while (dma_write_out) cy(1);
      chk("burst slot", a ? 4'h1 : 4'h8, {dma_read_out, dma_write_out, 1'b0, onchip_grant_out});
    end
    burst_auto_in = 4'h0;
    onchip_master_req_in = 1'b0;
    chan_req_in = 4'h0;
    onchip_master_arbitration_enable_in = 1'b0;
    cy(12);
  endtask
  // a short count, then a finished repeat, ends the owning channel with an escape
  task automatic t_size;
    remaining_count_in = 16'h0000;
    repeat_mode_in = 4'h2;
    for (int c = 0; c < 2; c++) begin
      size_error_enable_in = c ? 4'h0 : 4'h2;
      repeat_end_enable_in = c ? 4'h2 : 4'h0;
      repeat_size_done_in = c[0];
      transfer_enable_set_in = 4'h2;
      cy(1);
      transfer_enable_set_in = 4'h0;
      chan_req_in = 4'h2;
      cy(1);
      chan_req_in = 4'h0;
      chk("esc cause", 4'h2, escape_flag_out & ~transfer_enable_out & 4'h2);
      transfer_enable_clr_in = 4'h2;
      escape_flag_clr_in = 4'h2;
      cy(1);
      transfer_enable_clr_in = 4'h0;
      escape_flag_clr_in = 4'h0;
    end
  endtask
  task automatic t_cnt;
    counter_end_irq_enable_in = 4'h4;
    transfer_enable_set_in = 4'hc;
    cy(1);
    transfer_enable_set_in = 4'h0;
    counter_zero_in = 4'hc;
    cy(1);
    counter_zero_in = 4'h0;
    chk("end flag", 4'h4, counter_end_flag_out & 4'hc);
    chk("enable off", 4'h0, transfer_enable_out & 4'hc);
    cy(3);
    chk("end irq", 4'h4, counter_end_irq_out & 4'hc);
    counter_end_flag_clr_in = 4'h4;
    cy(1);
    counter_end_flag_clr_in = 4'h0;
    chk("end cleared", 4'h0, counter_end_irq_out | counter_end_flag_out);
  endtask
  // each overflow cause, first with its own enable off, then on
  task automatic t_esc;
    for (int i = 0; i < 2; i++) begin
      transfer_enable_set_in = 4'h8;
      cy(1);
      transfer_enable_set_in = 4'h0;
      for (int e = 0; e < 2; e++) begin
        source_area_overflow_enable_in = (i == 0 && e == 1) ? 4'h8 : 4'h0;
        dest_area_overflow_enable_in = (i == 1 && e == 1) ? 4'h8 : 4'h0;
        src_overflow_in = (i == 0) ? 4'h8 : 4'h0;
        dst_overflow_in = (i == 1) ? 4'h8 : 4'h0;
        cy(1);
        src_overflow_in = 4'h0;
        dst_overflow_in = 4'h0;
        chk("esc flag", e ? 4'h8 : 4'h0, escape_flag_out & 4'h8);
        chk("esc irq", e ? 4'h8 : 4'h0, escape_end_irq_out & 4'h8);
        chk("esc stop", e ? 4'h0 : 4'h8, transfer_enable_out & 4'h8);
      end
      escape_flag_clr_in = 4'h8;
      cy(1);
      escape_flag_clr_in = 4'h0;
      chk("esc cleared", 4'h0, escape_end_irq_out | escape_flag_out);
    end
  endtask
  // =====================================================
  // main sequence and watchdog
  initial begin
    cy(12);
    rst_n_in = 1'b1;
    cy(1);
    t_mask;
    t_off;
    t_burst;
    t_pair(1'b0);
    dma_external_in = 1'b1;
    t_pair(1'b1);
    t_cnt;
    t_esc;
    t_size;
    conclude;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    n_fail++;
    conclude;
  end
endmodule
